// ===== design/sme_top.sv
`timescale 1ns/1ns
module sme_top
#(
  parameter int         UPD_CYCLES = sme_pkg::UPD_CYC,
  parameter logic [6:0] EE_DEV     = 7'h50
)
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        eeprom_init_done,
  input  wire logic [2:0]  ioexp_int_n,
  input  wire logic [7:0]  port_on,
  input  wire logic [7:0]  link_up,
  input  wire logic [7:0]  link_act,
  input  wire logic [3:0]  hp_slot_ctl_en,
  input  wire logic [3:0]  attention_indicator_out,
  input  wire logic [3:0]  power_indicator_out,
  input  wire logic [3:0]  slot_power_enable_out,
  input  wire logic [3:0]  interlock_control_out,
  output logic [15:0]      exp_in0,
  output logic [15:0]      exp_in1,
  output logic [7:0]       power_good
);
  import sme_pkg::*;

  typedef enum logic [1:0]
  {
    M_IDLE = 2'b00,
    M_EE   = 2'b01,
    M_IOX  = 2'b10
  } sme_ctl_type;

  localparam int UPW = $clog2(UPD_CYCLES);

  logic [4:0]     s1_r;
  logic [4:0]     s2_r;
  logic           wr_en;
  logic           ee_wr;
  logic           sts_wr;
  logic [31:0]    rd_w;
  logic           err_w;
  logic [31:0]    prdata_r;
  logic           pslverr_r;
  logic [7:0]     ee_data_r;
  logic [15:0]    ee_loc_r;
  logic           ee_op_r;
  logic           ee_busy_r;
  logic           ee_done_r;
  logic           ee_req_r;
  logic [1:0]     sts_r;
  logic [7:0]     ad_r [0:5];
  logic [5:0]     cfg_set;
  logic [UPW-1:0] upd_r;
  logic           tick;
  logic [7:0]     hpb [0:3];
  logic [15:0]    des_w [0:5];
  logic [15:0]    dir_w [0:5];
  logic [7:0]     run_w [0:5];
  logic [7:0]     cfgm_w [0:5];
  logic [7:0]     mask_w [0:5];
  logic [15:0]    shd_r [0:5];
  logic [15:0]    in_r [0:2];
  logic [5:0]     need_cfg_r;
  logic [5:0]     svc_r;
  logic [2:0]     int_pend_r;
  logic [2:0]     pick;
  logic           anyw;
  logic [5:0]     pick_oh;
  sme_ctl_type    ctl_r;
  logic           go_r;
  logic           wait_r;
  logic [2:0]     job_e_r;
  logic [7:0]     job_m_r;
  logic [2:0]     cur_r;
  logic [2:0]     step_w;
  logic [7:0]     sd_w;
  logic [7:0]     wdat_r;
  logic           ee_go;
  logic           pick_go;
  logic           ee_fin;
  logic           iox_fin;
  logic [6:0]     e_dev;
  logic [1:0]     e_nwr;
  logic           e_rd;
  logic [7:0]     e_wb0;
  logic [7:0]     e_wb1;
  logic [7:0]     e_wb2;
  logic           eng_busy;
  logic           eng_done;
  logic           eng_nak;
  logic [7:0]     eng_rdata;
  logic           scl_lo;
  logic           sda_lo;

  // pins and interrupt lines pass two flops
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
    end
    else if (ce)
    begin
      s1_r <= {ioexp_int_n, sda_i, scl_i};
      s2_r <= s1_r;
    end
  end

  assign wr_en  = psel & penable & pwrite;
  assign ee_wr  = wr_en & (paddr == OFF_EE);
  assign sts_wr = wr_en & (paddr == OFF_STS);
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  always_comb
  begin
    rd_w  = 32'h0000_0000;
    err_w = 1'b0;
    case (paddr)
      OFF_EE:   rd_w = {ee_busy_r, ee_done_r, 5'h00, ee_op_r, ee_loc_r, ee_data_r};
      OFF_STS:  rd_w = {29'h0000_0000, eeprom_init_done, sts_r};
      OFF_AD0:  rd_w = {ad_r[3], ad_r[2], ad_r[1], ad_r[0]};
      OFF_AD1:  rd_w = {16'h0000, ad_r[5], ad_r[4]};
      OFF_IN01: rd_w = {in_r[1], in_r[0]};
      OFF_IN2:  rd_w = {16'h0000, in_r[2]};
      default:  err_w = 1'b1;
    endcase
  end

  // read data is captured in the setup cycle, so no wait states
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (ce & psel & ~penable)
    begin
      prdata_r  <= pwrite ? 32'h0000_0000 : rd_w;
      pslverr_r <= err_w;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ee_data_r <= 8'h00;
      ee_loc_r  <= 16'h0000;
      ee_op_r   <= 1'b0;
      ee_busy_r <= 1'b0;
      ee_done_r <= 1'b0;
      ee_req_r  <= 1'b0;
    end
    else if (ce)
    begin
      if (ee_wr)
      begin
        if (pstrb[1])
          ee_loc_r[7:0] <= pwdata[15:8];
        if (pstrb[2])
          ee_loc_r[15:8] <= pwdata[23:16];
        if (pstrb[3])
          ee_op_r <= pwdata[EE_OP_BIT];
        if (pstrb[0] & ~ee_busy_r)
        begin
          ee_data_r <= pwdata[7:0];
          ee_busy_r <= 1'b1;
          ee_done_r <= 1'b0;
          ee_req_r  <= 1'b1;
        end
      end
      if (ee_go)
        ee_req_r <= 1'b0;
      if (ee_fin)
      begin
        ee_busy_r <= 1'b0;
        ee_done_r <= 1'b1;
        if (ee_op_r & ~eng_nak)
          ee_data_r <= eng_rdata;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      sts_r <= 2'b00;
    else if (ce)
      sts_r <= (sts_r & ~({2{sts_wr & pstrb[0]}} & pwdata[1:0])) | {iox_fin & eng_nak, ee_fin & eng_nak};
  end

  for (genvar i = 0; i < 6; i++)
  begin : g_ad
    localparam logic [7:0] OFF = (i < 4) ? OFF_AD0 : OFF_AD1;
    assign cfg_set[i] = wr_en & (paddr == OFF) & pstrb[i % 4] & pwdata[8 * (i % 4) + AD_EN_BIT];
    always_ff @(posedge clk)
    begin
      if (sys_rst)
        ad_r[i] <= 8'h00;
      else if (ce & wr_en & (paddr == OFF) & pstrb[i % 4])
        ad_r[i] <= pwdata[8 * (i % 4) +: 8];
    end
  end

  assign tick = (upd_r == UPW'(UPD_CYCLES - 1));
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      upd_r <= '0;
    else if (ce)
      upd_r <= tick ? '0 : upd_r + 1'b1;
  end

  for (genvar p = 0; p < 4; p++)
  begin : g_hp
    logic [3:0] ctl;
    assign ctl = hp_slot_ctl_en[p] ? {interlock_control_out[p], slot_power_enable_out[p],
                                      power_indicator_out[p], attention_indicator_out[p]} : HP_DEF;
    assign hpb[p] = {port_on[p + 2] ? ctl : HP_NEG, HP_LOW};
  end

  for (genvar e = 0; e < 6; e++)
  begin : g_exp
    if (e < 2)
    begin : g_hot
      assign des_w[e]  = {hpb[e + 2], hpb[e]};
      assign dir_w[e]  = {DIR_HP, DIR_HP};
      assign cfgm_w[e] = CFG_HP;
      assign run_w[e]  = ((des_w[e] != shd_r[e]) ? UPD_BOTH : 8'h00) | (int_pend_r[e] ? RD_MASK : 8'h00);
    end
    else if (e == EXP_PG)
    begin : g_pg
      assign des_w[e]  = {PG_DEF, PG_DEF};
      assign dir_w[e]  = {DIR_IN, DIR_IN};
      assign cfgm_w[e] = CFG_PG;
      assign run_w[e]  = ((des_w[e][7:0] != shd_r[e][7:0]) ? UPD_LO : 8'h00) | (int_pend_r[e] ? RD_MASK : 8'h00);
    end
    else if (e == EXP_LNK)
    begin : g_lnk
      assign des_w[e]  = {~(link_act & port_on), ~(link_up & port_on)};
      assign dir_w[e]  = {DIR_OUT, DIR_OUT};
      assign cfgm_w[e] = CFG_LNK;
      assign run_w[e]  = (des_w[e] != shd_r[e]) ? UPD_BOTH : 8'h00;
    end
    else
    begin : g_none
      assign des_w[e]  = 16'h0000;
      assign dir_w[e]  = 16'h0000;
      assign cfgm_w[e] = 8'h00;
      assign run_w[e]  = 8'h00;
    end
    assign mask_w[e] = ~ad_r[e][AD_EN_BIT] ? 8'h00 : need_cfg_r[e] ? cfgm_w[e] : svc_r[e] ? run_w[e] : 8'h00;
  end

  always_comb
  begin
    pick = 3'd0;
    anyw = 1'b0;
    for (int i = 5; i >= 0; i--)
    begin
      if (mask_w[i] != 8'h00)
      begin
        pick = 3'(i);
        anyw = 1'b1;
      end
    end
  end

  always_comb
  begin
    step_w = 3'd0;
    for (int i = 7; i >= 0; i--)
    begin
      if (job_m_r[i])
        step_w = 3'(i);
    end
  end

  always_comb
  begin
    unique case (step_w)
      3'd0: sd_w = des_w[job_e_r][7:0];
      3'd1: sd_w = des_w[job_e_r][15:8];
      3'd4: sd_w = dir_w[job_e_r][7:0];
      3'd5: sd_w = dir_w[job_e_r][15:8];
      default: sd_w = INV_NONE;
    endcase
  end

  // bus held until power-on load is done
  assign ee_go   = (ctl_r == M_IDLE) & eeprom_init_done & ~eng_busy & ee_req_r;
  assign pick_go = (ctl_r == M_IDLE) & eeprom_init_done & ~eng_busy & ~ee_req_r & anyw;
  assign pick_oh = pick_go ? 6'(6'b000001 << pick) : 6'b000000;
  assign ee_fin  = (ctl_r == M_EE) & eng_done;
  assign iox_fin = (ctl_r == M_IOX) & wait_r & eng_done;

  // pending flags: a new event beats the clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      need_cfg_r <= 6'b000000;
      svc_r      <= 6'b000000;
      int_pend_r <= 3'b000;
    end
    else if (ce)
    begin
      need_cfg_r <= (need_cfg_r & ~pick_oh) | cfg_set;
      svc_r      <= (svc_r & ~pick_oh) | {6{tick}};
      int_pend_r <= (int_pend_r & ~pick_oh[2:0]) | ~s2_r[4:2];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctl_r   <= M_IDLE;
      go_r    <= 1'b0;
      wait_r  <= 1'b0;
      job_e_r <= 3'd0;
      job_m_r <= 8'h00;
      cur_r   <= 3'd0;
      wdat_r  <= 8'h00;
    end
    else if (ce)
    begin
      go_r <= 1'b0;
      unique case (ctl_r)
        M_IDLE:
        begin
          if (ee_go)
          begin
            ctl_r <= M_EE;
            go_r  <= 1'b1;
          end
          else if (pick_go)
          begin
            ctl_r   <= M_IOX;
            job_e_r <= pick;
            job_m_r <= mask_w[pick];
            wait_r  <= 1'b0;
          end
        end
        M_EE:
          if (eng_done)
            ctl_r <= M_IDLE;
        M_IOX:
        begin
          if (!wait_r)
          begin
            if (job_m_r == 8'h00)
              ctl_r <= M_IDLE;
            else
            begin
              cur_r  <= step_w;
              wdat_r <= sd_w;
              go_r   <= 1'b1;
              wait_r <= 1'b1;
            end
          end
          else if (eng_done)
          begin
            wait_r  <= 1'b0;
            job_m_r <= eng_nak ? 8'h00 : (job_m_r & ~(8'h01 << cur_r));
          end
        end
        default: ctl_r <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      shd_r <= '{6{16'h0000}};
      in_r  <= '{3{16'h0000}};
    end
    else if (ce & iox_fin & ~eng_nak)
    begin
      if (cur_r[2:1] == 2'b00)
        shd_r[job_e_r][8 * cur_r[0] +: 8] <= wdat_r;
      if ((cur_r[2:1] == 2'b11) & (job_e_r < 3'd3))
        in_r[job_e_r[1:0]][8 * cur_r[0] +: 8] <= eng_rdata;
    end
  end

  always_comb
  begin
    if (ctl_r == M_EE)
    begin
      e_dev = EE_DEV;
      e_rd  = ee_op_r;
      e_nwr = ee_op_r ? 2'd2 : 2'd3;
      e_wb0 = ee_loc_r[15:8];
      e_wb1 = ee_loc_r[7:0];
      e_wb2 = ee_data_r;
    end
    else
    begin
      // command byte is the register index
      e_dev = ad_r[job_e_r][6:0];
      e_rd  = (cur_r[2:1] == 2'b11);
      e_nwr = e_rd ? 2'd1 : 2'd2;
      e_wb0 = {5'b00000, STEP_REG[cur_r]};
      e_wb1 = wdat_r;
      e_wb2 = 8'h00;
    end
  end

  sme_smb_engine sme_smb_engine_i
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .scl_s   (s2_r[0]),
    .sda_s   (s2_r[1]),
    .go      (go_r),
    .rd      (e_rd),
    .dev     (e_dev),
    .nwr     (e_nwr),
    .wb0     (e_wb0),
    .wb1     (e_wb1),
    .wb2     (e_wb2),
    .busy    (eng_busy),
    .done    (eng_done),
    .nak     (eng_nak),
    .rdata   (eng_rdata),
    .scl_lo  (scl_lo),
    .sda_lo  (sda_lo)
  );

  assign scl_o      = 1'b0;
  assign sda_o      = 1'b0;
  assign scl_oe     = scl_lo;
  assign sda_oe     = sda_lo;
  assign exp_in0    = in_r[0];
  assign exp_in1    = in_r[1];
  assign power_good = in_r[2][15:8];
endmodule

// ===== include/sme_pkg.sv
package sme_pkg;
  localparam int CLK_NS  = 10;
  localparam int QTR_NS  = 2500;
  localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
  localparam int UPD_MS  = 40;
  localparam int UPD_CYC = UPD_MS * 1000000 / CLK_NS;

  localparam logic [7:0] OFF_EE   = 8'h00;
  localparam logic [7:0] OFF_STS  = 8'h04;
  localparam logic [7:0] OFF_AD0  = 8'h08;
  localparam logic [7:0] OFF_AD1  = 8'h0C;
  localparam logic [7:0] OFF_IN01 = 8'h10;
  localparam logic [7:0] OFF_IN2  = 8'h14;
  localparam int         EE_OP_BIT = 24;
  localparam int         AD_EN_BIT = 7;

  localparam logic [3:0] HP_DEF   = 4'h5;
  localparam logic [3:0] HP_NEG   = 4'h3;
  localparam logic [3:0] HP_LOW   = 4'hF;
  localparam logic [7:0] PG_DEF   = 8'hFF;
  localparam logic [7:0] DIR_HP   = 8'h0F;
  localparam logic [7:0] DIR_IN   = 8'hFF;
  localparam logic [7:0] DIR_OUT  = 8'h00;
  localparam logic [7:0] INV_NONE = 8'h00;

  localparam logic [7:0] CFG_HP   = 8'hFF;
  localparam logic [7:0] CFG_PG   = 8'hFD;
  localparam logic [7:0] CFG_LNK  = 8'h3F;
  localparam logic [7:0] UPD_BOTH = 8'h03;
  localparam logic [7:0] UPD_LO   = 8'h01;
  localparam logic [7:0] RD_MASK  = 8'hC0;
  localparam int         EXP_PG   = 2;
  localparam int         EXP_LNK  = 4;
  localparam logic [2:0] STEP_REG [0:7] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h1};
  localparam logic [4:0] SYNC_RST = 5'h1F;
endpackage

// ===== design/sme_smb_engine.sv
`timescale 1ns/1ns
module sme_smb_engine
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       scl_s,
  input  wire logic       sda_s,
  input  wire logic       go,
  input  wire logic       rd,
  input  wire logic [6:0] dev,
  input  wire logic [1:0] nwr,
  input  wire logic [7:0] wb0,
  input  wire logic [7:0] wb1,
  input  wire logic [7:0] wb2,
  output logic            busy,
  output logic            done,
  output logic            nak,
  output logic [7:0]      rdata,
  output logic            scl_lo,
  output logic            sda_lo
);
  import sme_pkg::*;

  typedef enum logic [2:0]
  {
    E_IDLE  = 3'b000,
    E_START = 3'b001,
    E_TX    = 3'b010,
    E_RX    = 3'b011,
    E_STOP  = 3'b100
  } sme_eng_type;

  localparam int QW = $clog2(QTR_CYC);

  sme_eng_type   st_r;
  logic [QW-1:0] qc_r;
  logic [1:0]    q_r;
  logic [3:0]    bit_r;
  logic [1:0]    bn_r;
  logic          rph_r;
  logic [7:0]    sh_r;
  logic [6:0]    dev_r;
  logic [1:0]    nwr_r;
  logic          rd_r;
  logic [7:0]    wb_r [0:2];
  logic          qend;
  logic          qt;

  assign qend = (qc_r == QW'(QTR_CYC - 1));
  // sample quarter waits while a target stretches the clock
  assign qt = ce & qend & ~((q_r == 2'd2) & ~scl_s);
  assign busy = (st_r != E_IDLE);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      qc_r <= '0;
    else if (ce)
    begin
      if ((st_r == E_IDLE) | qt)
        qc_r <= '0;
      else if (!qend)
        qc_r <= qc_r + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r   <= E_IDLE;
      q_r    <= 2'd0;
      bit_r  <= 4'd0;
      bn_r   <= 2'd0;
      rph_r  <= 1'b0;
      sh_r   <= 8'h00;
      dev_r  <= 7'h00;
      nwr_r  <= 2'd0;
      rd_r   <= 1'b0;
      wb_r   <= '{8'h00, 8'h00, 8'h00};
      scl_lo <= 1'b0;
      sda_lo <= 1'b0;
      done   <= 1'b0;
      nak    <= 1'b0;
      rdata  <= 8'h00;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (st_r == E_IDLE)
      begin
        q_r <= 2'd0;
        if (go)
        begin
          dev_r <= dev;
          nwr_r <= nwr;
          rd_r  <= rd;
          wb_r  <= '{wb0, wb1, wb2};
          bn_r  <= 2'd0;
          rph_r <= 1'b0;
          nak   <= 1'b0;
          st_r  <= E_START;
        end
      end
      else if (qt)
      begin
        q_r <= q_r + 1'b1;
        unique case (st_r)
          E_START:
            unique case (q_r)
              2'd0: sda_lo <= 1'b0;
              2'd1: scl_lo <= 1'b0;
              2'd2: sda_lo <= 1'b1;
              2'd3:
              begin
                scl_lo <= 1'b1;
                sh_r   <= {dev_r, rph_r};
                bit_r  <= 4'd0;
                st_r   <= E_TX;
              end
            endcase
          E_TX, E_RX:
            unique case (q_r)
              2'd0: sda_lo <= (st_r == E_TX) & (bit_r != 4'd8) & ~sh_r[7];
              2'd1: scl_lo <= 1'b0;
              2'd2:
              begin
                if (bit_r != 4'd8)
                  sh_r <= {sh_r[6:0], sda_s};
                else if ((st_r == E_TX) & sda_s)
                  nak <= 1'b1;
              end
              2'd3:
              begin
                scl_lo <= 1'b1;
                if (bit_r != 4'd8)
                  bit_r <= bit_r + 1'b1;
                else
                begin
                  bit_r <= 4'd0;
                  if (st_r == E_RX)
                  begin
                    rdata <= sh_r;
                    st_r  <= E_STOP;
                  end
                  else if (nak)
                    st_r <= E_STOP;
                  else if (rph_r)
                    st_r <= E_RX;
                  else if (bn_r != nwr_r)
                  begin
                    sh_r <= wb_r[bn_r];
                    bn_r <= bn_r + 1'b1;
                  end
                  else if (rd_r)
                  begin
                    rph_r <= 1'b1;
                    st_r  <= E_START;
                  end
                  else
                    st_r <= E_STOP;
                end
              end
            endcase
          E_STOP:
            unique case (q_r)
              2'd0: sda_lo <= 1'b1;
              2'd1: scl_lo <= 1'b0;
              2'd2: sda_lo <= 1'b0;
              2'd3:
              begin
                st_r <= E_IDLE;
                done <= 1'b1;
              end
            endcase
          default: st_r <= E_IDLE;
        endcase
      end
    end
  end
endmodule

// ===== bench/sme_sva.sv
`timescale 1ns/1ns
module sme_sva
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        eeprom_init_done,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic [15:0] exp_in0,
  input wire logic [15:0] exp_in1,
  input wire logic [7:0]  power_good
);
  import sme_pkg::*;
  wire setup = psel && !penable && ce;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_ready_high: assert property (pready) else $error("pready low");
  a_pins_zero: assert property (!scl_o && !sda_o) else $error("pin value not zero");
  a_init_gate: assert property (!eeprom_init_done |-> !scl_oe && !sda_oe)
    else $error("bus used before load done");
  a_unmap_err: assert property (setup && paddr > OFF_IN2 |=> pslverr) else $error("no error on unmapped");
  a_map_ok: assert property (setup && paddr <= OFF_IN2 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("error on mapped");
  a_in_gate: assert property (!eeprom_init_done |=> $stable({exp_in0, exp_in1, power_good}))
    else $error("expander inputs moved before load done");
  a_sts_init: assert property (setup && !pwrite && paddr == OFF_STS |=> prdata[2] == $past(eeprom_init_done))
    else $error("status load bit wrong");
  a_rdata_hold: assert property (!setup |=> $stable(prdata)) else $error("prdata moved");
  a_scl_low: assert property ($rose(scl_oe) |=> scl_oe [*8]) else $error("scl low too short");
  a_scl_high: assert property ($fell(scl_oe) |=> !scl_oe [*8]) else $error("scl high too short");
endmodule
bind sme_top sme_sva sme_sva_i (.clk, .sys_rst, .ce, .psel, .penable, .pwrite, .paddr, .eeprom_init_done,
  .prdata, .pready, .pslverr, .scl_o, .scl_oe, .sda_o, .sda_oe, .exp_in0, .exp_in1, .power_good);

// ===== bench/sme_bus_model.sv
`timescale 1ns/1ns
module sme_bus_model
(
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_pull
);
  logic [7:0] sh;
  logic [7:0] log_b [0:7];
  logic [7:0] rdat;
  int         bits = 0;
  int         n = 0;
  int         ntx = 0;
  bit         first = 0;
  bit         rd = 0;
  bit         stopped = 1;
  initial sda_pull = 1'b0;
  // start or repeated start keeps the log across a restart
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      bits = 0;
      first = 1;
      rd = 0;
      if (stopped)
        n = 0;
      stopped = 0;
    end
  always @(posedge sda)
    if (scl === 1'b1 && !stopped)
    begin
      stopped = 1;
      ntx++;
    end
  always @(posedge scl)
  begin
    sh = {sh[6:0], sda};
    bits++;
    if (bits == 8 && !(rd && !first))
    begin
      log_b[n[2:0]] = sh;
      n++;
      rd = first && sh[0];
      rdat = log_b[2] ^ 8'hA5;
    end
  end
  // ack written bytes, shift out read data msb first
  always @(negedge scl)
  begin
    if (bits == 9)
    begin
      bits = 0;
      first = 0;
    end
    if (bits == 8)
      sda_pull <= !(rd && !first);
    else
      sda_pull <= rd && !first && !rdat[7 - bits];
  end
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end
module tb;
  import sme_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        init_done = 1'b0;
  logic        ce = 1'b1;
  logic [2:0]  ioexp_int_n = 3'h7;
  logic [7:0]  port_on = 8'hFF;
  logic [7:0]  link_up = 8'h0F;
  logic [7:0]  link_act = 8'h03;
  logic [3:0]  hp_slot_ctl_en = 4'hE;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] q;
  logic        err;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         scl_oe;
  wire         sda_oe;
  wire         pull;
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe || pull);
  int          errors = 0;
  int          num_checks = 0;
  sme_top #(.UPD_CYCLES(50000)) sme_top_i (.clk, .sys_rst, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda), .sda_o(),
    .sda_oe, .eeprom_init_done(init_done), .ioexp_int_n, .port_on, .link_up, .link_act, .hp_slot_ctl_en,
    .attention_indicator_out(4'hF), .power_indicator_out(4'h0), .slot_power_enable_out(4'hF),
    .interlock_control_out(4'h0), .exp_in0(), .exp_in1(), .power_good());
  sme_bus_model sme_bus_model_i (.scl, .sda, .sda_pull(pull));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_regs;
    apb(1'b0, 8'h40, 32'h0, 4'h0);
    `CHK("unmapped error", 1'b1, err)
    `CHK("unmapped data", 32'h0, q)
    apb(1'b0, OFF_STS, 32'h0, 4'h0);
    `CHK("status idle", 3'h0, q[2:0])
    ce <= 1'b0;
    apb(1'b1, OFF_AD1, 32'h0000_0055, 4'h1);
    ce <= 1'b1;
    apb(1'b1, OFF_AD1, 32'h0000_3300, 4'h2);
    apb(1'b0, OFF_AD1, 32'h0, 4'h0);
    `CHK("frozen and field", 32'h3300, q)
  endtask
  task automatic ee_wait;
    do
    begin
      repeat (200) @(posedge clk);
      apb(1'b0, OFF_EE, 32'h0, 4'h0);
    end
    while (q[30] !== 1'b1);
  endtask
  task automatic t_ee_exp;
    apb(1'b1, OFF_EE, 32'h0101_2300, 4'hE);
    apb(1'b0, OFF_EE, 32'h0, 4'h0);
    `CHK("busy before start", 1'b0, q[31])
    apb(1'b1, OFF_EE, 32'h0101_2300, 4'h1);
    apb(1'b1, OFF_EE, 32'h0000_0077, 4'h1);
    apb(1'b0, OFF_EE, 32'h0, 4'h0);
    `CHK("start during busy", 9'h100, {q[31], q[7:0]})
    repeat (1000) @(posedge clk);
    `CHK("traffic before load", 33'h1, {sme_bus_model_i.ntx, sme_bus_model_i.stopped})
    init_done <= 1'b1;
    ee_wait;
    `CHK("busy done", 2'b01, q[31:30])
    `CHK("read byte", 8'h86, q[7:0])
    `CHK("ee frame", 32'hA00123A1, {sme_bus_model_i.log_b[0], sme_bus_model_i.log_b[1],
      sme_bus_model_i.log_b[2], sme_bus_model_i.log_b[3]})
    apb(1'b0, OFF_STS, 32'h0, 4'h0);
    `CHK("status after", 3'h4, q[2:0])
    // load location and write, then start
    apb(1'b1, OFF_EE, 32'h0004_5600, 4'hE);
    apb(1'b1, OFF_EE, 32'h0000_00C3, 4'h1);
    ee_wait;
    `CHK("write done", 10'h1C3, {q[31:30], q[7:0]})
    `CHK("ee write frame", 32'hA00456C3, {sme_bus_model_i.log_b[0], sme_bus_model_i.log_b[1],
      sme_bus_model_i.log_b[2], sme_bus_model_i.log_b[3]})
    `CHK("ee write bytes", 4, sme_bus_model_i.n)
    apb(1'b1, OFF_AD0, 32'h0000_00A0, 4'h1);
    wait (sme_bus_model_i.ntx == 3);
    `CHK("exp first write", 24'h40025F, {sme_bus_model_i.log_b[0], sme_bus_model_i.log_b[1],
      sme_bus_model_i.log_b[2]})
    `CHK("exp byte count", 3, sme_bus_model_i.n)
  endtask
  task finish_test;
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    forever #5 clk = !clk;
  end
  initial
  begin
    repeat (130000) @(posedge clk);
    errors++;
    finish_test;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_ee_exp;
    finish_test;
  end
endmodule
